/* pkg/isv_pkg.sv */
// Functional notes
// - traps from executed instructions ignore the enable flag and priority levels
// - the undefined opcode instruction always raises the undefined-instruction trap
// - overflow-trap instruction traps only while the overflow flag is 1
// - every breakpoint instruction raises the breakpoint trap
// - numbered software interrupt takes an operand 0 to 63 and raises it
// - numbers 0 to 31 share vector entries with the peripheral interrupts
// - numbers 0 to 31 save stack-select flag, clear it, restore on return
// - numbers 32 to 63 leave the stack-select flag unchanged
// - low on the active-low reset pin holds reset; reset is non-maskable
// - reset, watchdog, address match, single step, debugger are non-maskable specials
// - debug flag at 1 raises single step after each completed instruction
// - with match enable 1, interrupt just before instruction at match address
// - a match address that is not an instruction start never matches
// - peripheral and pin interrupts are masked by enable flag and priorities
// - each external pin requests on its selected edge, rising or falling
// - accepted interrupt branches to handler address read from its vector
// - fixed entries: undefined fffdc, overflow fffe0, breakpoint fffe4, four bytes
// - fixed entries: match fffe8, step fffec, watchdog ffff0, debugger ffff4, reset ffffc
// - breakpoint entry holding ff bytes redirects to relocatable breakpoint entry
// - maskable sources have enable gating and priority; non-maskable have neither
// - relocatable table: 256 bytes at base register, entry n at base plus 4n
// - maskable accepted only with enable 1, request 1, level above processor level
// - global enable flag resets to 0; 1 enables, 0 disables all maskable
// - request bit set on request, cleared when accepted and vector taken
package isv_pkg;
    localparam int NSRC       = 22;
    localparam int NEXT       = 6;
    localparam int EXT_BASE   = 16;
    localparam int PW         = 3;
    localparam int AW         = 20;
    localparam int USTK_DEPTH = 8;
    localparam int ENT_BYTES  = 4;
    localparam int VTB_SPAN   = 256;

    localparam logic [AW-1:0] FIX_UND = 20'hfffdc;
    localparam logic [AW-1:0] FIX_OVF = 20'hfffe0;
    localparam logic [AW-1:0] FIX_BRK = 20'hfffe4;
    localparam logic [AW-1:0] FIX_AM  = 20'hfffe8;
    localparam logic [AW-1:0] FIX_SS  = 20'hfffec;
    localparam logic [AW-1:0] FIX_WDT = 20'hffff0;
    localparam logic [AW-1:0] FIX_DBC = 20'hffff4;
    localparam logic [AW-1:0] FIX_RSV = 20'hffff8;
    localparam logic [AW-1:0] FIX_RST = 20'hffffc;
    localparam logic [7:0]    BRK_REDIR   = 8'hff;
    localparam logic [5:0]    BRK_VNUM    = 6'h00;
    localparam logic [5:0]    SHARED_LAST = 6'h1f;

    localparam logic [11:0] OFF_CTRL  = 12'h000;
    localparam logic [11:0] OFF_AMADR = 12'h004;
    localparam logic [11:0] OFF_VTB   = 12'h008;
    localparam logic [11:0] OFF_REQ   = 12'h00c;
    localparam logic [11:0] OFF_STAT  = 12'h010;
    localparam logic [11:0] OFF_PRIO0 = 12'h014;
    localparam logic [11:0] OFF_PRIO1 = 12'h018;
    localparam logic [11:0] OFF_PRIO2 = 12'h01c;
    localparam logic [11:0] OFF_EDGE  = 12'h020;
    localparam int CTRL_I   = 0;
    localparam int CTRL_IPL = 1;
    localparam int CTRL_U   = 4;
    localparam int CTRL_D   = 5;
    localparam int CTRL_AM  = 6;
    localparam int PRIO_PER = 8;
    localparam logic [2:0]    IPL_RST  = 3'h0;
    localparam logic [PW-1:0] PRIO_RST = 3'h0;
    localparam logic [NEXT-1:0] EDGE_RST = 6'h00;
    localparam logic [AW-1:0] VTB_RST  = 20'h00000;

    // table entry of each maskable source: transfer 0/1, conversion, auto
    // transfer, serial 0/1 tx/rx, A timers 0-4, B timers 0-2, pins 0-5
    localparam logic [5:0] SRC_VEC [NSRC] = '{
        6'h0b, 6'h0c, 6'h0e, 6'h0f, 6'h11, 6'h12, 6'h13, 6'h14,
        6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c,
        6'h1d, 6'h1e, 6'h1f, 6'h07, 6'h08, 6'h09};

    typedef enum logic [2:0] {INSTR_NONE, INSTR_UNDEF, INSTR_INTO, INSTR_BRK,
                              INSTR_INT} isv_instr_t;
    typedef enum logic [3:0] {SRC_RST, SRC_UND, SRC_OVF, SRC_BRK, SRC_SWI, SRC_WDT,
                              SRC_DBC, SRC_AM, SRC_SS, SRC_PERI} isv_src_t;
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_CHECK} isv_state_t;
    typedef struct packed {
        logic       done;
        isv_instr_t kind;
        logic [5:0] num;
    } isv_retire_t;
    typedef struct packed {
        logic          start;
        logic [AW-1:0] addr;
    } isv_fetch_t;
    typedef struct packed {
        logic          req;
        logic [AW-1:0] addr;
    } isv_vrd_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } isv_vrsp_t;
    typedef struct packed {
        logic          take;
        logic          fixed;
        logic [5:0]    num;
        logic [AW-1:0] handler;
    } isv_accept_t;
endpackage

/* hdl/isv_top.sv */
module isv_top
    import isv_pkg::*;
#(
    parameter int USTK = USTK_DEPTH
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire isv_retire_t       retire,
    input  wire logic              ovf_flag,
    input  wire isv_fetch_t        fetch,
    input  wire logic              reset_pin_n,
    input  wire logic              wdt_req,
    input  wire logic              dbc_req,
    input  wire logic [15:0]       periph_req,
    input  wire logic [NEXT-1:0]   ext_pin,
    input  wire logic              iret,
    output isv_vrd_t               vrd,
    input  wire isv_vrsp_t         vrsp,
    output isv_accept_t            accept,
    output logic                   cpu_reset,
    output logic                   u_flag
);
    if (USTK < 2) begin : g_chk
        $error("USTK must be at least 2");
    end

    // ========================================================
    // register bus
    logic              pready_reg;
    logic              pslverr_reg;
    logic [31:0]       prdata_reg;
    logic [31:0]       rdata;
    logic              hit;
    logic              acc;
    logic              wr;
    logic              i_reg;
    logic [2:0]        ipl_reg;
    logic              u_reg;
    logic              d_reg;
    logic              am_en_reg;
    logic [AW-1:0]     amadr_reg;
    logic [AW-1:0]     vtb_reg;
    logic [NEXT-1:0]   edge_reg;
    logic [NEXT-1:0]   pin_prev_reg;
    logic [NSRC-1:0]   req_reg;
    logic [PW*24-1:0]  prio_flat;
    logic [PW-1:0]     prio_reg [NSRC];
    isv_state_t        st_reg;

    assign acc = psel && penable && !pready_reg;
    assign wr  = acc && pwrite;

    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0;
        case (paddr)
            OFF_CTRL:  rdata = {25'h0, am_en_reg, d_reg, u_reg, ipl_reg, i_reg};
            OFF_AMADR: rdata = {12'h0, amadr_reg};
            OFF_VTB:   rdata = {12'h0, vtb_reg};
            OFF_REQ:   rdata = {10'h0, req_reg};
            OFF_STAT:  rdata = {24'h0, accept.num, st_reg};
            OFF_PRIO0: rdata = {8'h0, prio_flat[23:0]};
            OFF_PRIO1: rdata = {8'h0, prio_flat[47:24]};
            OFF_PRIO2: rdata = {8'h0, prio_flat[71:48]};
            OFF_EDGE:  rdata = {26'h0, edge_reg};
            default:   hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= acc;
            pslverr_reg <= acc && !hit;
            if (acc && !pwrite) begin
                prdata_reg <= rdata;
            end
        end
    end

    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata  = prdata_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            i_reg     <= 1'b0;
            ipl_reg   <= IPL_RST;
            d_reg     <= 1'b0;
            am_en_reg <= 1'b0;
            amadr_reg <= '0;
            vtb_reg   <= VTB_RST;
            edge_reg  <= EDGE_RST;
        end else if (wr) begin
            case (paddr)
                OFF_CTRL: begin
                    i_reg     <= pwdata[CTRL_I];
                    ipl_reg   <= pwdata[CTRL_IPL +: 3];
                    d_reg     <= pwdata[CTRL_D];
                    am_en_reg <= pwdata[CTRL_AM];
                end
                OFF_AMADR: amadr_reg <= pwdata[AW-1:0];
                OFF_VTB:   vtb_reg   <= pwdata[AW-1:0];
                OFF_EDGE:  edge_reg  <= pwdata[NEXT-1:0];
                default: begin
                end
            endcase
        end
    end

    // ========================================================
    // maskable sources
    logic          done;
    isv_src_t      src_reg;
    logic [5:0]    num_reg;
    logic [4:0]    best_idx;
    logic          best_ok;
    logic [PW-1:0] best_lvl;
    logic          mask_hit;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_prev_reg <= '0;
        end else begin
            pin_prev_reg <= ext_pin;
        end
    end

    assign prio_flat[PW*24-1:PW*NSRC] = '0;

    for (genvar i = 0; i < NSRC; i++) begin : g_src
        logic set_i;
        logic clr_i;
        if (i >= EXT_BASE) begin : g_pin
            localparam int P = i - EXT_BASE;
            assign set_i = edge_reg[P] ? (ext_pin[P] && !pin_prev_reg[P])
                                       : (!ext_pin[P] && pin_prev_reg[P]);
        end else begin : g_per
            assign set_i = periph_req[i];
        end
        assign clr_i = (wr && paddr == OFF_REQ && !pwdata[i])
                     || (done && src_reg == SRC_PERI && num_reg == SRC_VEC[i]);
        assign prio_flat[PW*i +: PW] = prio_reg[i];
        always_ff @(posedge core_clk) begin
            if (rst) begin
                req_reg[i]  <= 1'b0;
                prio_reg[i] <= PRIO_RST;
            end else begin
                req_reg[i] <= set_i || (req_reg[i] && !clr_i);
                if (wr && paddr == OFF_PRIO0 + 12'((i / PRIO_PER) * 4)) begin
                    prio_reg[i] <= pwdata[PW*(i % PRIO_PER) +: PW];
                end
            end
        end
    end

    always_comb begin
        best_ok  = 1'b0;
        best_idx = 5'h0;
        best_lvl = ipl_reg;
        for (int i = 0; i < NSRC; i++) begin
            if (req_reg[i] && prio_reg[i] > best_lvl) begin
                best_ok  = 1'b1;
                best_idx = 5'(i);
                best_lvl = prio_reg[i];
            end
        end
        mask_hit = i_reg && best_ok;
    end

    // ========================================================
    // non-maskable pending events
    isv_instr_t trap_kind_reg;
    logic [5:0] trap_num_reg;
    logic       rst_pend;
    logic       wdt_pend;
    logic       dbc_pend;
    logic       am_pend;
    logic       ss_pend;
    logic       take;
    isv_src_t   sel_src;
    logic       sel_ok;
    logic       sel_var;
    logic [5:0] sel_num;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            trap_kind_reg <= INSTR_NONE;
            trap_num_reg  <= 6'h0;
        end else if (retire.done && (retire.kind == INSTR_UNDEF
                     || retire.kind == INSTR_BRK
                     || retire.kind == INSTR_INT
                     || (retire.kind == INSTR_INTO && ovf_flag))) begin
            trap_kind_reg <= retire.kind;
            trap_num_reg  <= retire.num;
        end else if (take && !rst_pend) begin
            trap_kind_reg <= INSTR_NONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rst_pend <= 1'b1;
            wdt_pend <= 1'b0;
            dbc_pend <= 1'b0;
            am_pend  <= 1'b0;
            ss_pend  <= 1'b0;
        end else begin
            rst_pend <= !reset_pin_n || (rst_pend && !(take && sel_src == SRC_RST));
            wdt_pend <= wdt_req || (wdt_pend && !(take && sel_src == SRC_WDT));
            dbc_pend <= dbc_req || (dbc_pend && !(take && sel_src == SRC_DBC));
            // only instruction start addresses are compared
            am_pend  <= (fetch.start && am_en_reg && fetch.addr == amadr_reg)
                        || (am_pend && !(take && sel_src == SRC_AM));
            ss_pend  <= (retire.done && d_reg)
                        || (ss_pend && !(take && sel_src == SRC_SS));
        end
    end

    always_comb begin
        sel_ok  = 1'b1;
        sel_var = 1'b0;
        sel_num = 6'h0;
        sel_src = SRC_RST;
        if (rst_pend) begin
            sel_src = SRC_RST;
        end else if (trap_kind_reg != INSTR_NONE) begin
            case (trap_kind_reg)
                INSTR_UNDEF: sel_src = SRC_UND;
                INSTR_INTO:  sel_src = SRC_OVF;
                INSTR_BRK:   sel_src = SRC_BRK;
                default: begin
                    sel_src = SRC_SWI;
                    sel_var = 1'b1;
                    sel_num = trap_num_reg;
                end
            endcase
        end else if (wdt_pend) begin
            sel_src = SRC_WDT;
        end else if (dbc_pend) begin
            sel_src = SRC_DBC;
        end else if (am_pend) begin
            sel_src = SRC_AM;
        end else if (ss_pend) begin
            sel_src = SRC_SS;
        end else if (mask_hit) begin
            sel_src = SRC_PERI;
            sel_var = 1'b1;
            sel_num = SRC_VEC[best_idx];
        end else begin
            sel_ok = 1'b0;
        end
    end

    assign take = st_reg == ST_IDLE && sel_ok && reset_pin_n;

    // ========================================================
    // stack select flag
    logic [USTK-1:0] ustk_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            u_reg    <= 1'b0;
            ustk_reg <= '0;
        end else if (take) begin
            ustk_reg <= {ustk_reg[USTK-2:0], u_reg};
            if (sel_var && sel_num <= SHARED_LAST) begin
                u_reg <= 1'b0;
            end
        end else if (iret) begin
            u_reg    <= ustk_reg[0];
            ustk_reg <= {1'b0, ustk_reg[USTK-1:1]};
        end else if (wr && paddr == OFF_CTRL) begin
            u_reg <= pwdata[CTRL_U];
        end
    end

    assign u_flag = u_reg;

    // ========================================================
    // vector fetch and branch
    logic [AW-1:0] fix_addr;
    logic [AW-1:0] ent_addr;
    logic [31:0]   ent_reg;
    logic [1:0]    idx_reg;
    logic          var_reg;
    logic          redir;
    isv_vrd_t      vrd_reg;
    isv_accept_t   acc_reg;
    logic          cpu_reset_reg;

    always_comb begin
        case (sel_src)
            SRC_UND: fix_addr = FIX_UND;
            SRC_OVF: fix_addr = FIX_OVF;
            SRC_BRK: fix_addr = FIX_BRK;
            SRC_AM:  fix_addr = FIX_AM;
            SRC_SS:  fix_addr = FIX_SS;
            SRC_WDT: fix_addr = FIX_WDT;
            SRC_DBC: fix_addr = FIX_DBC;
            default: fix_addr = FIX_RST;
        endcase
        ent_addr = sel_var ? vtb_reg + AW'({sel_num, 2'b00}) : fix_addr;
    end

    assign redir = src_reg == SRC_BRK && !var_reg && ent_reg == {ENT_BYTES{BRK_REDIR}};
    assign done  = st_reg == ST_CHECK && !redir;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_reg  <= ST_IDLE;
            src_reg <= SRC_RST;
            var_reg <= 1'b0;
            num_reg <= 6'h0;
            idx_reg <= 2'h0;
            ent_reg <= 32'h0;
            vrd_reg <= '0;
            acc_reg <= '0;
        end else if (!reset_pin_n) begin
            st_reg       <= ST_IDLE;
            vrd_reg.req  <= 1'b0;
            acc_reg.take <= 1'b0;
        end else begin
            acc_reg.take <= 1'b0;
            case (st_reg)
                ST_IDLE: begin
                    if (take) begin
                        st_reg  <= ST_FETCH;
                        src_reg <= sel_src;
                        var_reg <= sel_var;
                        num_reg <= sel_num;
                        idx_reg <= 2'h0;
                        vrd_reg <= '{req: 1'b1, addr: ent_addr};
                    end
                end
                ST_FETCH: begin
                    if (vrsp.valid) begin
                        ent_reg[8*idx_reg +: 8] <= vrsp.data;
                        vrd_reg.addr <= vrd_reg.addr + 20'h1;
                        idx_reg      <= idx_reg + 2'h1;
                        if (idx_reg == 2'(ENT_BYTES - 1)) begin
                            vrd_reg.req <= 1'b0;
                            st_reg      <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    if (redir) begin
                        var_reg <= 1'b1;
                        num_reg <= BRK_VNUM;
                        idx_reg <= 2'h0;
                        vrd_reg <= '{req: 1'b1, addr: vtb_reg + AW'({BRK_VNUM, 2'b00})};
                        st_reg  <= ST_FETCH;
                    end else begin
                        acc_reg <= '{take: 1'b1, fixed: !var_reg, num: num_reg,
                                     handler: ent_reg[AW-1:0]};
                        st_reg  <= ST_IDLE;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cpu_reset_reg <= 1'b1;
        end else begin
            cpu_reset_reg <= !reset_pin_n;
        end
    end

    assign vrd       = vrd_reg;
    assign accept    = acc_reg;
    assign cpu_reset = cpu_reset_reg;

    // ========================================================
    // checks
    a_undef_nomask: assert property (@(posedge core_clk) disable iff (rst)
        retire.done && retire.kind == INSTR_UNDEF && !i_reg && st_reg == ST_IDLE && !sel_ok
        |=> trap_kind_reg == INSTR_UNDEF
        ##1 (!$past(reset_pin_n) || st_reg == ST_FETCH && vrd.addr == FIX_UND))
        else $error("undefined opcode trap not raised");
    a_into_quiet: assert property (@(posedge core_clk) disable iff (rst)
        retire.done && retire.kind == INSTR_INTO && !ovf_flag && trap_kind_reg == INSTR_NONE
        |=> trap_kind_reg == INSTR_NONE)
        else $error("overflow trap without overflow flag");
    a_brk_raise: assert property (@(posedge core_clk) disable iff (rst)
        retire.done && retire.kind == INSTR_BRK |=> trap_kind_reg == INSTR_BRK)
        else $error("breakpoint trap missed");
    a_swi_entry: assert property (@(posedge core_clk) disable iff (rst)
        take && sel_src == SRC_SWI
        |=> vrd.req && vrd.addr == $past(vtb_reg) + AW'({$past(trap_num_reg), 2'b00}))
        else $error("software interrupt entry address wrong");
    a_u_clear: assert property (@(posedge core_clk) disable iff (rst)
        take && sel_var && sel_num <= SHARED_LAST |=> !u_flag ##0 ustk_reg[0] == $past(u_reg))
        else $error("stack select not saved and cleared");
    a_u_keep: assert property (@(posedge core_clk) disable iff (rst)
        take && sel_var && sel_num > SHARED_LAST |=> u_flag == $past(u_reg))
        else $error("stack select changed for high number");
    a_reset_hold: assert property (@(posedge core_clk) disable iff (rst)
        !reset_pin_n |=> cpu_reset && rst_pend && st_reg == ST_IDLE)
        else $error("reset pin not honoured");
    a_step_raise: assert property (@(posedge core_clk) disable iff (rst)
        retire.done && d_reg |=> ss_pend)
        else $error("single step not raised");
    a_mask_gate: assert property (@(posedge core_clk) disable iff (rst)
        take && sel_src == SRC_PERI
        |-> i_reg && best_lvl > ipl_reg && !rst_pend && !wdt_pend && !am_pend)
        else $error("maskable accepted against gate");
    a_byte_order: assert property (@(posedge core_clk) disable iff (rst)
        st_reg == ST_FETCH && vrsp.valid && idx_reg == 2'h0 && reset_pin_n
        |=> ent_reg[7:0] == $past(vrsp.data) && vrd.addr == $past(vrd.addr) + 20'h1)
        else $error("vector bytes out of order");
endmodule // isv_top

/* verif/isv_mem.sv */
// ====
// vector memory: byte at addr is addr[7:0], ff in the breakpoint entry while redir is set
module isv_mem
    import isv_pkg::*;
(
    input  wire logic      core_clk,
    input  wire isv_vrd_t  vrd,
    input  wire logic      slow,
    input  wire logic      redir,
    output isv_vrsp_t      vrsp
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       tick = 1'b0;
    logic [7:0] last = 8'h00;
    always @(posedge core_clk) begin
        tick <= ~tick;
        if (vrsp.valid) last <= vrsp.data;
    end
    always_comb begin
        vrsp.valid = vrd.req & (~slow | tick);
        vrsp.data  = ~last;
        if (vrsp.valid) begin
            vrsp.data = vrd.addr[7:0];
            if (redir && vrd.addr[19:2] == FIX_BRK[19:2]) vrsp.data = BRK_REDIR;
        end
    end
endmodule // isv_mem

/* verif/interrupt_source_vectoring_bench.sv */
module interrupt_source_vectoring_bench
    import isv_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic ovf_flag = 1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic reset_pin_n = 0, wdt_req = 0, iret = 0, cpu_reset, u_flag, slow = 0, redir = 0;
    logic dbc_req = 0; // debugger-only sources stay idle
    logic [15:0] periph_req = '0;
    logic [NEXT-1:0] ext_pin = '0;
    isv_retire_t retire = '0;
    isv_fetch_t fetch = '0;
    isv_vrd_t vrd;
    isv_vrsp_t vrsp;
    isv_accept_t accept;
    int fails = 0, checks_done = 0;
    localparam logic [19:0] VTB = 20'h01000;

    always #2.5 core_clk = ~core_clk;

    isv_top isv_top_inst (
        .core_clk    (core_clk),
        .rst         (rst),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .retire      (retire),
        .ovf_flag    (ovf_flag),
        .fetch       (fetch),
        .reset_pin_n (reset_pin_n),
        .wdt_req     (wdt_req),
        .dbc_req     (dbc_req),
        .periph_req  (periph_req),
        .ext_pin     (ext_pin),
        .iret        (iret),
        .vrd         (vrd),
        .vrsp        (vrsp),
        .accept      (accept),
        .cpu_reset   (cpu_reset),
        .u_flag      (u_flag)
    );

    isv_mem isv_mem_inst (
        .core_clk (core_clk),
        .vrd      (vrd),
        .slow     (slow),
        .redir    (redir),
        .vrsp     (vrsp)
    );

    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
        end while (!pready && n < 50);
        q = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) begin
            check(32'h0, 32'h1, "bus timeout");
            results();
        end
    endtask

    task automatic expect_acc(input logic fx, input logic [5:0] nm, input logic [19:0] h,
                              input string m);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (!accept.take && n < 100);
        check({4'h0, accept}, {4'h0, 1'h1, fx, nm, h}, m);
        if (n >= 100) begin
            results();
        end
    endtask

    task automatic expect_quiet(input string m);
        logic seen;
        seen = 1'h0;
        repeat (20) begin
            @(negedge core_clk);
            seen = seen | accept.take;
        end
        check({31'h0, seen}, 32'h0, m);
    endtask

    task automatic run(input isv_instr_t k, input logic [5:0] nm);
        @(posedge core_clk);
        retire <= '{done: 1'h1, kind: k, num: nm};
        @(posedge core_clk);
        retire <= '0;
    endtask

    task automatic pulse_periph();
        @(posedge core_clk);
        periph_req <= 16'h0001;
        @(posedge core_clk);
        periph_req <= 16'h0000;
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'h0;
        @(negedge core_clk);
        check({31'h0, cpu_reset}, 32'h1, "cpu reset held");
        @(posedge core_clk);
        reset_pin_n <= 1'h1;
        expect_acc(1'h1, 6'h00, 20'hefdfc, "reset vector");
        apb(1'h1, OFF_VTB, {12'h000, VTB});
        apb(1'h0, OFF_VTB, 32'h0);
        check(q, {12'h000, VTB}, "table base");
        slow <= 1'h1;
        run(INSTR_UNDEF, 6'h00);
        expect_acc(1'h1, 6'h00, 20'hedddc, "undefined opcode");
        slow <= 1'h0;
        ovf_flag <= 1'h0;
        run(INSTR_INTO, 6'h00);
        expect_quiet("overflow trap without flag");
        ovf_flag <= 1'h1;
        run(INSTR_INTO, 6'h00);
        expect_acc(1'h1, 6'h00, 20'h2e1e0, "overflow trap");
        run(INSTR_BRK, 6'h00);
        expect_acc(1'h1, 6'h00, 20'h6e5e4, "breakpoint fixed");
        redir <= 1'h1;
        run(INSTR_BRK, 6'h00);
        expect_acc(1'h0, 6'h00, 20'h20100, "breakpoint redirect");
        redir <= 1'h0;
        apb(1'h1, OFF_CTRL, 32'h00000010);
        run(INSTR_INT, 6'h28);
        expect_acc(1'h0, 6'h28, 20'h2a1a0, "software interrupt 40");
        check({31'h0, u_flag}, 32'h1, "stack select kept");
        run(INSTR_INT, 6'h05);
        expect_acc(1'h0, 6'h05, 20'h61514, "software interrupt 5");
        check({31'h0, u_flag}, 32'h0, "stack select cleared");
        @(posedge core_clk);
        iret <= 1'h1;
        @(posedge core_clk);
        iret <= 1'h0;
        @(negedge core_clk);
        check({31'h0, u_flag}, 32'h1, "stack select restored");
        apb(1'h1, OFF_PRIO0, 32'h00000003);
        pulse_periph();
        expect_quiet("peripheral with enable off");
        apb(1'h0, OFF_REQ, 32'h0);
        check(q, 32'h00000001, "request bit set");
        apb(1'h1, OFF_CTRL, 32'h00000001);
        expect_acc(1'h0, 6'h0b, 20'he2d2c, "peripheral vector");
        apb(1'h0, OFF_REQ, 32'h0);
        check(q, 32'h00000000, "request bit cleared");
        apb(1'h1, OFF_EDGE, 32'h00000001);
        apb(1'h1, OFF_PRIO2, 32'h00000003);
        @(posedge core_clk);
        ext_pin <= 6'h01;
        expect_acc(1'h0, 6'h1d, 20'h67574, "pin rising edge");
        apb(1'h1, OFF_CTRL, 32'h00000007);
        pulse_periph();
        expect_quiet("level not above processor level");
        apb(1'h1, OFF_AMADR, 32'h00000400);
        apb(1'h1, OFF_CTRL, 32'h00000040);
        @(posedge core_clk);
        fetch <= '{start: 1'h0, addr: 20'h00400};
        @(posedge core_clk);
        fetch <= '0;
        expect_quiet("match on non-start byte");
        @(posedge core_clk);
        fetch <= '{start: 1'h1, addr: 20'h00400};
        @(posedge core_clk);
        fetch <= '0;
        expect_acc(1'h1, 6'h00, 20'hae9e8, "address match");
        slow <= 1'h1;
        @(posedge core_clk);
        wdt_req <= 1'h1;
        @(posedge core_clk);
        wdt_req <= 1'h0;
        expect_acc(1'h1, 6'h00, 20'h2f1f0, "watchdog");
        results();
    end
endmodule // interrupt_source_vectoring_bench
